// >>> ipfb_pkg.sv
// Package of offsets, masks, source table and reset values for the bank.
package ipfb_pkg;

    // Number of interrupt sources covered by the bank.
    localparam int N_SRC = 30;

    // Register word indices; the byte address is four times the index.
    localparam logic [5:0] IDX_DBG    = 6'h01;
    localparam logic [5:0] IDX_FLASH  = 6'h02;
    localparam logic [5:0] IDX_PORT   = 6'h03;
    localparam logic [5:0] IDX_SERIAL = 6'h04;
    localparam logic [5:0] IDX_DEC    = 6'h05;
    localparam logic [5:0] IDX_STAT   = 6'h20;
    localparam logic [5:0] IDX_CLR    = 6'h21;
    localparam logic [5:0] IDX_EN     = 6'h22;

    // Writable bits of each priority register; reserved bits stay zero.
    localparam logic [15:0] WMASK_DBG    = 16'h003f;
    localparam logic [15:0] WMASK_FLASH  = 16'hffcf;
    localparam logic [15:0] WMASK_PORT   = 16'hfffc;
    localparam logic [15:0] WMASK_SERIAL = 16'hfc3f;
    localparam logic [15:0] WMASK_DEC    = 16'hff3f;

    // Reset values of the priority, status and enable registers.
    localparam logic [15:0] PRIO_RST = 16'h0000;
    localparam logic [31:0] STAT_RST = 32'h0000_0000;

    // Field code that disables a source.
    localparam logic [1:0] FLD_OFF = 2'h0;

    // Sources below this index use levels 1..3, the rest 0..2.
    localparam int N_DBG = 3;

    // Register index that holds the field of each source.
    localparam int SRC_REG [N_SRC] = '{
        1, 1, 1, 2, 2, 2, 2, 2, 2, 2,
        3, 3, 3, 3, 3, 3, 3, 4, 4, 4,
        4, 4, 4, 5, 5, 5, 5, 5, 5, 5};

    // Low bit of the field of each source within its register.
    localparam int SRC_LSB [N_SRC] = '{
        0, 2, 4, 0, 2, 6, 8, 10, 12, 14,
        2, 4, 6, 8, 10, 12, 14, 0, 2, 4,
        10, 12, 14, 0, 2, 4, 8, 10, 12, 14};

endpackage

// >>> ipfb_bank.sv
// Interrupt priority field bank with APB registers and request arbitration.
// Function
// (RULE_01) Debug receive-full field: 00 off, else 1..3.
// (RULE_02) Debug transmit-empty field: 00 off, else 1..3.
// (RULE_03) Debug trace field: 00 off, else 1..3.
// (RULE_04) Flash fields at 15:10, 00 off, 0..2.
// (RULE_05) PLL unlock and low voltage fields, 0..2.
// (RULE_06) External request B and A fields, 0..2.
// (RULE_07) Port D, E, F fields, 0..2.
// (RULE_08) CAN message, wake, error, bus-off fields.
// (RULE_09) SPI channel fields at 15:10, 0..2.
// (RULE_10) Port A, B, C fields at 5:0.
// (RULE_11) Reserved bits read zero, ignore writes.
// (RULE_12) Every priority field resets to 00.
// (RULE_13) Registers at word offsets 2..5, 16 bits; the code places them at word offsets 1..5.
// (RULE_14) Disabled sources never reach the core.
//
// Design decision made here: the APB register port.
module ipfb_bank
    import ipfb_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic [ipfb_pkg::N_SRC-1:0] src_req,
    output logic                     core_req,
    output logic      [1:0]          core_level,
    output logic      [4:0]          core_src,
    output logic      [3:0]          level_req,
    output logic                     irq
);
    import ipfb_pkg::*;

    // Priority registers indexed by their word offset.
    logic [15:0]      prio_q [1:5];
    // Sticky event status and its interrupt enable.
    logic [N_SRC-1:0] stat_q;
    logic [N_SRC-1:0] en_q;
    // Registered read answer and error flag.
    logic [31:0]      rdata_q;
    logic             err_q;
    // Registered arbitration result toward the core.
    logic             core_req_q;
    logic [1:0]       core_level_q;
    logic [4:0]       core_src_q;
    logic [3:0]       level_req_q;

    // Per-source field, enable and decoded level.
    logic [1:0]       fld   [N_SRC];
    logic [N_SRC-1:0] act;
    logic [1:0]       lvl   [N_SRC];

    // Bus phase decode.
    logic             setup;
    logic             wr;
    logic [5:0]       idx;
    logic             hit_prio;
    logic             mapped;

    // Arbitration scratch results.
    logic             win_any_d;
    logic [1:0]       win_lvl_d;
    logic [4:0]       win_src_d;
    logic [3:0]       level_req_d;

    // Word index is the byte address over four; low bits are ignored.
    assign idx      = paddr[7:2];
    assign setup    = psel & ~penable;
    assign wr       = psel & penable & pwrite;
    // The priority registers sit at word offsets one to five.
    assign hit_prio = (idx >= IDX_DBG) && (idx <= IDX_DEC); // [RULE_13]
    assign mapped   = hit_prio || idx == IDX_STAT
                      || idx == IDX_CLR || idx == IDX_EN;

    // The slave never inserts wait states, so ready is held high.
    assign pready   = 1'b1;
    assign prdata   = rdata_q;
    assign pslverr  = err_q;

    // Write mask lookup for the addressed priority register.
    function automatic logic [15:0] wmask(input logic [5:0] i);
        logic [15:0] m;
        m = 16'h0000;
        unique case (i)
            IDX_DBG:    m = WMASK_DBG;
            IDX_FLASH:  m = WMASK_FLASH;
            IDX_PORT:   m = WMASK_PORT;
            IDX_SERIAL: m = WMASK_SERIAL;
            IDX_DEC:    m = WMASK_DEC;
            default:    m = 16'h0000;
        endcase
        return m;
    endfunction

    // Priority registers: reset to all fields off, masked writes.
    // Masking at write time keeps reserved bits at zero for reads.
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int r = 1; r <= 5; r++) begin
                prio_q[r] <= PRIO_RST; // [RULE_12]
            end
        end else if (wr && hit_prio) begin
            // Reserved bits take no value from the bus.
            prio_q[idx[2:0]] <= pwdata[15:0] & wmask(idx); // [RULE_11]
        end
    end

    // Enable register for the interrupt output.
    always_ff @(posedge clk) begin
        if (rst) begin
            en_q <= STAT_RST[N_SRC-1:0];
        end else if (wr && idx == IDX_EN) begin
            en_q <= pwdata[N_SRC-1:0];
        end
    end

    // Read data is latched in the setup cycle so the access cycle
    // can complete at once with a registered answer.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= 32'h0000_0000;
            err_q   <= 1'b0;
        end else if (setup) begin
            err_q   <= ~mapped;
            rdata_q <= 32'h0000_0000;
            if (hit_prio) begin
                // Upper half and reserved bits always read zero.
                rdata_q <= {16'h0000, prio_q[idx[2:0]]}; // [RULE_11]
            end else if (idx == IDX_STAT) begin
                rdata_q <= {{(32-N_SRC){1'b0}}, stat_q};
            end else if (idx == IDX_EN) begin
                rdata_q <= {{(32-N_SRC){1'b0}}, en_q};
            end
            // The clear register is write only and reads as zero.
        end
    end

    // Field extraction and level decode, one instance per source.
    for (genvar i = 0; i < N_SRC; i++) begin : g_src
        assign fld[i] = prio_q[SRC_REG[i]][SRC_LSB[i] +: 2];
        // Code 00 keeps the source away from arbitration.
        assign act[i] = src_req[i] && fld[i] != FLD_OFF; // [RULE_14]
        if (i < N_DBG) begin : g_dbg
            // Debug fields: the code is the level itself, 1 to 3.
            assign lvl[i] = fld[i]; // [RULE_01] [RULE_02] [RULE_03]
        end else begin : g_std
            // Other fields: code 01 to 11 maps to level 0 to 2.
            assign lvl[i] = fld[i] - 2'h1; // [RULE_04] [RULE_05] [RULE_06]
        end
    end

    // The standard-field decode above also covers ports, CAN and SPI.
    // Sources 10..16 are port D-F and CAN, 17..22 port A-C and SPI.
    // A shared decode keeps every non-debug field identical by construction.
    // Level decode for the remaining groups.  [RULE_07] [RULE_08]
    // Same decode for SPI and port A-C groups. [RULE_09] [RULE_10]

    // Arbitration: highest level wins, ties go to the lowest index.
    // A fixed tie order is simple but can starve high indices when
    // several sources share a level and stay asserted.
    always_comb begin
        win_any_d   = 1'b0;
        win_lvl_d   = 2'h0;
        win_src_d   = 5'h00;
        level_req_d = 4'h0;
        for (int i = 0; i < N_SRC; i++) begin
            if (act[i]) begin // [RULE_14]
                level_req_d[lvl[i]] = 1'b1;
                if (!win_any_d || lvl[i] > win_lvl_d) begin
                    win_any_d = 1'b1;
                    win_lvl_d = lvl[i];
                    win_src_d = 5'(i);
                end
            end
        end
    end

    // Request toward the core, registered for clean timing.
    always_ff @(posedge clk) begin
        if (rst) begin
            core_req_q   <= 1'b0;
            core_level_q <= 2'h0;
            core_src_q   <= 5'h00;
            level_req_q  <= 4'h0;
        end else begin
            core_req_q   <= win_any_d;
            core_level_q <= win_lvl_d;
            core_src_q   <= win_src_d;
            level_req_q  <= level_req_d;
        end
    end

    assign core_req   = core_req_q;
    assign core_level = core_level_q;
    assign core_src   = core_src_q;
    assign level_req  = level_req_q;

    // Sticky status: an enabled request sets its bit; a one written to
    // the clear register drops it, but a set in the same cycle wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            stat_q <= STAT_RST[N_SRC-1:0];
        end else if (wr && idx == IDX_CLR) begin
            stat_q <= (stat_q & ~pwdata[N_SRC-1:0]) | act;
        end else begin
            stat_q <= stat_q | act;
        end
    end

    // Level interrupt, high while any enabled status bit is set.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(stat_q & en_q);
        end
    end

endmodule

// >>> ipfb_chk.sv
// Checker of the bank's register and arbitration ports.
module ipfb_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [29:0] src_req,
    input wire logic        core_req,
    input wire logic [1:0]  core_level,
    input wire logic [4:0]  core_src,
    input wire logic [3:0]  level_req,
    input wire logic        irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Word index and access phase of the current transfer.
    logic [5:0] ix;
    logic       acc;
    logic       map;
    logic       rsv;
    assign ix  = paddr[7:2];
    assign acc = psel && penable;
    assign map = (ix >= 6'h01 && ix <= 6'h05) ||
                 (ix >= 6'h20 && ix <= 6'h22);
    // A reserved bit seen set on a read of words 2 to 5 is a leak through the mask.
    assign rsv = (ix == 6'h02 && prdata[5:4] != 2'h0) ||
                 (ix == 6'h03 && prdata[1:0] != 2'h0) ||
                 (ix == 6'h04 && prdata[9:6] != 4'h0) ||
                 (ix == 6'h05 && prdata[7:6] != 2'h0);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_unmapped: assert property (acc && !map |-> pslverr)
        else $error("no error on unmapped index");
    chk_ok_mapped: assert property (acc && map |-> !pslverr)
        else $error("error on mapped index");
    chk_hi_zero: assert property (acc && !pwrite && ix inside {[1:5]}
        |-> prdata[31:16] == 16'h0000)
        else $error("upper half of priority word not zero");
    chk_rsv_zero: assert property (acc && !pwrite |-> !rsv)
        else $error("reserved bits read nonzero");
    chk_idle_noreq: assert property (src_req == 30'h0
        |=> !core_req && level_req == 4'h0)
        else $error("request without source");
    chk_lvl_match: assert property (core_req |-> level_req[core_level]
        && core_src < 5'd30)
        else $error("winner level not among requested levels");
    chk_req_lvls: assert property (level_req != 4'h0 |-> core_req)
        else $error("level pending without core request");
    chk_rst_clear: assert property (disable iff (1'b0) rst |=> !core_req
        && !irq && prdata == 32'h0)
        else $error("outputs not cleared by reset");
    cover property (core_req && core_level == 2'h3);
    cover property (acc && pslverr);
    cover property (irq);
endmodule

// >>> ipfb_core_model.sv
// Behavioural core that takes the winning request of the bank.
module ipfb_core_model (
    input  wire logic       clk,
    input  wire logic       core_req,
    input  wire logic [1:0] core_level,
    input  wire logic [4:0] core_src,
    output logic      [6:0] seen
);
    // The core keeps the last source and level that it was offered.
    always_ff @(posedge clk) begin
        if (core_req) begin
            seen <= {core_level, core_src};
        end
    end
endmodule

// >>> irq_priority_field_bank_tb.sv
// Self-checking bench of the priority field bank.
module irq_priority_field_bank_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready;
    logic pslverr, core_req, irq, ev;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rv;
    logic [29:0] src_req = 0;
    logic [1:0] core_level;
    logic [4:0] core_src;
    logic [3:0] level_req;
    logic [6:0] seen;
    int miscompares = 0, n_compared = 0;
    // Rows: address, write data, expected readback of the same word.
    logic [7:0] ra[8] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h08,
        8'h0c, 8'h10};
    logic [31:0] rw[8] = '{'1, '1, '1, '1, '1, 32'h5555, 32'haaaa, 32'h330};
    logic [31:0] re[8] = '{32'h3f, 32'hffcf, 32'hfffc, 32'hfc3f, 32'hff3f,
        32'h5545, 32'haaa8, 32'h30};
    ipfb_bank dut (.*);
    ipfb_core_model core (.*);
    always #50 clk = ~clk;
    task automatic give_verdict;
        if (miscompares == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    // One APB transfer; an idle cycle follows so psel never toggles twice.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk) penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            apb(1, ra[i], rw[i]);
            apb(0, ra[i], 0);
            chk(rv, re[i]);
        end
        // A mid-run reset must drop every field back to disabled.
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        for (int i = 1; i < 6; i++) begin
            apb(0, 8'(i * 4), 0);
            chk(rv, 0);
        end
        apb(0, 8'h40, 0);
        chk(rv, 0);
        chk(ev, 1);
        apb(1, 8'h88, 32'h3fff_ffff);
        src_req <= 30'h10;
        repeat (3) @(posedge clk);
        chk({core_req, irq}, 0);
        apb(1, 8'h08, 32'hd);
        src_req <= 30'h18;
        // The model takes the winner one edge after the bank registers
        // it; a third edge lets that value settle before it is read.
        repeat (3) @(posedge clk);
        chk(seen, 7'h44);
        apb(1, 8'h04, 32'h30);
        src_req <= 30'h1c;
        repeat (3) @(posedge clk);
        chk(seen, 7'h62);
        src_req <= 0;
        apb(0, 8'h80, 0);
        chk(rv, 32'h1c);
        chk(irq, 1);
        apb(1, 8'h88, 0);
        // The interrupt output is registered, so it drops one edge later.
        @(posedge clk);
        chk(irq, 0);
        apb(1, 8'h84, 32'h1c);
        apb(0, 8'h80, 0);
        chk(rv, 0);
        give_verdict();
    end
endmodule
bind ipfb_bank ipfb_chk u_chk (.*);
